// ---- design/vic_defines.vh ----
// Constants for the vectored interrupt controller
`ifndef VIC_DEFINES_VH
`define VIC_DEFINES_VH
// Source counts and widths
`define VIC_NIRQ         118
`define VIC_NSYNC        122
`define VIC_PRI_WORDS    30
`define VIC_LAST_IRQ     7'h75
`define VIC_IRQ_BASE     7'h08
// Vector table geometry
`define VIC_PRIMARY_BASE 24'h000004
`define VIC_ALT_OFFSET   24'h000100
`define VIC_ALT_BIT      15
`define VIC_TRAP_TOP     4'hF
// Register byte offsets
`define VIC_OFF_FLAG     12'h000
`define VIC_OFF_EN       12'h040
`define VIC_OFF_PRI      12'h080
`define VIC_OFF_CTRL2    12'h180
`define VIC_OFF_LEVEL    12'h184
`define VIC_OFF_TRAP     12'h188
`define VIC_OFF_STAT     12'h18C
`define VIC_SPAN_FLAG    12'h020
`define VIC_SPAN_PRI     12'h078
// Field masks and reset value
`define VIC_FLAG_MASK    128'h003F_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF
`define VIC_PRI_MASK     16'h7777
`define VIC_TRAP_MASK    16'h001E
`define VIC_CTRL2_MASK   16'h8000
`define VIC_LEVEL_MASK   16'h0007
`define VIC_ZERO16       16'h0000
// Bus responses
`define VIC_RESP_OKAY    2'h0
`define VIC_RESP_SLVERR  2'h2
`endif

// ---- design/vic_sync.v ----
// Two-stage synchroniser for request and trap lines
`timescale 1ns/100ps
`include "vic_defines.vh"
module vic_sync
(
  // Clock and reset
  input  wire                    clk_in,
  input  wire                    sys_rst_in,
  // Lines
  input  wire [`VIC_NSYNC-1:0]   async_in,
  output reg  [`VIC_NSYNC-1:0]   sync_out
);

  reg [`VIC_NSYNC-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      meta     <= {`VIC_NSYNC{1'b0}};
      sync_out <= {`VIC_NSYNC{1'b0}};
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // vic_sync

// ---- design/vic_pri_mem.v ----
// Priority field memory with two registered read ports
`timescale 1ns/100ps
`include "vic_defines.vh"
module vic_pri_mem
(
  // Clock and reset
  input  wire        clk_in,
  input  wire        sys_rst_in,
  // Write port with byte strobes
  input  wire        wr_en_in,
  input  wire [4:0]  wr_addr_in,
  input  wire [1:0]  wr_strb_in,
  input  wire [15:0] wr_data_in,
  // Scan read port
  input  wire [4:0]  a_addr_in,
  output reg  [15:0] a_data_out,
  // Bus read port
  input  wire [4:0]  b_addr_in,
  output reg  [15:0] b_data_out
);

  reg [15:0] mem [0:`VIC_PRI_WORDS-1];
  integer    i;
  // Unused field bits are dropped before storage so they always read zero
  wire [15:0] wr_masked = wr_data_in & `VIC_PRI_MASK;

  // Words are cleared on reset so every source starts disabled
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      for (i = 0; i < `VIC_PRI_WORDS; i = i + 1)
        mem[i] <= `VIC_ZERO16;
      a_data_out <= `VIC_ZERO16;
      b_data_out <= `VIC_ZERO16;
    end
    else
    begin
      if (wr_en_in && wr_strb_in[0])
        mem[wr_addr_in][7:0] <= wr_masked[7:0];
      if (wr_en_in && wr_strb_in[1])
        mem[wr_addr_in][15:8] <= wr_masked[15:8];
      a_data_out <= mem[a_addr_in];
      b_data_out <= mem[b_addr_in];
    end
  end

endmodule // vic_pri_mem

// ---- design/vic_top.v ----
// Vectored interrupt controller with AXI4-Lite register access
// Function
// - Merge all requests into one core request
// - Seven user priority levels plus traps
// - Each source has its own vector
// - Equal levels resolved by fixed order
// - Constant entry and return latency
// - Primary table starts at 000004h, step two
// - Table holds 126 vectors, 118 interrupts
// - First eight vectors are unmaskable traps
// - Trap vectors 0-7 at fixed addresses
// - Each vector is a 24-bit address
// - Lower table address wins ties
// - Interrupt N at 000014h plus 2N
// - Flag/enable at N/16, priority at N/4
// - Alternate table after primary, select bit 15
// - Select bit routes all vectors to alternate
// - Reset clears registers, controller not involved
// - Request flags sticky until software clears
// - Three-bit priority field per source
// - Level high bit read-only for software
// - Taken vector and level latched for reading
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "vic_defines.vh"
module vic_top
(
  // Clock and reset
  input  wire                  clk_in,
  input  wire                  sys_rst_in,
  // Request sources
  input  wire [`VIC_NIRQ-1:0]  irq_line_in,
  input  wire [3:0]            trap_event_in,
  // Processor core handshake
  input  wire                  core_ack_in,
  input  wire                  core_ret_in,
  input  wire [3:0]            core_ret_level_in,
  output reg                   irq_req_out,
  output reg  [23:0]           vec_addr_out,
  output reg  [6:0]            vec_num_out,
  output reg  [3:0]            new_level_out,
  output reg  [3:0]            cpu_level_out,
  // AXI4-Lite write channels
  input  wire [11:0]           s_axi_awaddr_in,
  input  wire                  s_axi_awvalid_in,
  output reg                   s_axi_awready_out,
  input  wire [31:0]           s_axi_wdata_in,
  input  wire [3:0]            s_axi_wstrb_in,
  input  wire                  s_axi_wvalid_in,
  output reg                   s_axi_wready_out,
  output reg  [1:0]            s_axi_bresp_out,
  output reg                   s_axi_bvalid_out,
  input  wire                  s_axi_bready_in,
  // AXI4-Lite read channels
  input  wire [11:0]           s_axi_araddr_in,
  input  wire                  s_axi_arvalid_in,
  output reg                   s_axi_arready_out,
  output reg  [31:0]           s_axi_rdata_out,
  output reg  [1:0]            s_axi_rresp_out,
  output reg                   s_axi_rvalid_out,
  input  wire                  s_axi_rready_in
);

  // Byte-strobe merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0]  strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // Aligned address inside a window
  function in_win;
    input [11:0] addr;
    input [11:0] base;
    input [11:0] span;
    begin
      in_win = ({addr[11:2], 2'h0} >= base) && ({addr[11:2], 2'h0} < base + span);
    end
  endfunction

  // Any mapped register
  function mapped;
    input [11:0] addr;
    reg   [11:0] wa;
    begin
      wa     = {addr[11:2], 2'h0};
      mapped = in_win(addr, `VIC_OFF_FLAG, `VIC_SPAN_FLAG)
            || in_win(addr, `VIC_OFF_EN, `VIC_SPAN_FLAG)
            || in_win(addr, `VIC_OFF_PRI, `VIC_SPAN_PRI)
            || wa == `VIC_OFF_CTRL2 || wa == `VIC_OFF_LEVEL
            || wa == `VIC_OFF_TRAP || wa == `VIC_OFF_STAT;
    end
  endfunction

  // Vector number to table address
  function [23:0] vec_addr;
    input [6:0] num;
    input       alt;
    begin
      vec_addr = `VIC_PRIMARY_BASE + (alt ? `VIC_ALT_OFFSET : 24'h000000)
               + {16'h0000, num, 1'b0};
    end
  endfunction

  // Read path stages
  localparam RD_IDLE = 2'h0;
  localparam RD_WAIT = 2'h1;
  localparam RD_LOAD = 2'h2;

  // State
  reg  [127:0] flags;
  reg  [127:0] en;
  reg  [15:0]  trap;
  reg  [15:0]  ctrl2;
  reg  [6:0]   stat_num;
  reg  [3:0]   stat_lvl;
  reg  [6:0]   idx;
  reg  [6:0]   eval_num;
  reg          eval_ok;
  reg          best_v;
  reg  [6:0]   best_n;
  reg  [2:0]   best_p;
  reg          aw_held;
  reg          w_held;
  reg  [11:0]  wr_addr;
  reg  [15:0]  wdata_h;
  reg  [1:0]   wstrb_h;
  reg  [11:0]  rd_addr;
  reg  [1:0]   rd_stage;
  reg  [127:0] next_flags;
  reg  [127:0] next_en;
  reg  [15:0]  next_trap;
  reg          next_bv;
  reg  [6:0]   next_bn;
  reg  [2:0]   next_bp;
  reg          trap_hit;
  reg  [6:0]   trap_n;
  reg  [15:0]  rd_mux;
  reg  [2:0]   cand_p;
  integer      n;
  wire [`VIC_NSYNC-1:0] line_sync;
  wire [15:0]  mem_a;
  wire [15:0]  mem_b;
  wire [11:0]  wa = {wr_addr[11:2], 2'h0};
  wire [11:0]  wr_rel = wr_addr - `VIC_OFF_PRI;
  wire [11:0]  rd_rel = rd_addr - `VIC_OFF_PRI;
  wire [11:0]  ra = {rd_addr[11:2], 2'h0};
  wire         wr_do = aw_held && w_held && !s_axi_bvalid_out;
  wire         ack_take = core_ack_in && irq_req_out;
  wire         level_wr = wr_do && wa == `VIC_OFF_LEVEL;
  wire         restart = ack_take || core_ret_in || level_wr;
  wire         finalize = eval_ok && eval_num == `VIC_LAST_IRQ;

  // Pin-side lines cross into the clock domain
  vic_sync u_sync
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({trap_event_in, irq_line_in}),
    .sync_out   (line_sync)
  );

  // Priority fields, four per word at N/4
  vic_pri_mem u_pri
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .wr_en_in   (wr_do && in_win(wr_addr, `VIC_OFF_PRI, `VIC_SPAN_PRI)),
    .wr_addr_in (wr_rel[6:2]),
    .wr_strb_in (wstrb_h),
    .wr_data_in (wdata_h),
    .a_addr_in  (idx[6:2]),
    .a_data_out (mem_a),
    .b_addr_in  (rd_rel[6:2]),
    .b_data_out (mem_b)
  );

  // Flag, enable and trap next values; a hardware set beats a software clear
  always @*
  begin
    next_flags = flags;
    next_en    = en;
    next_trap  = trap;
    if (wr_do && in_win(wr_addr, `VIC_OFF_FLAG, `VIC_SPAN_FLAG))
      next_flags[{wr_addr[4:2], 4'h0} +: 16] =
        merge16(flags[{wr_addr[4:2], 4'h0} +: 16], wdata_h, wstrb_h);
    if (wr_do && in_win(wr_addr, `VIC_OFF_EN, `VIC_SPAN_FLAG))
      next_en[{wr_addr[4:2], 4'h0} +: 16] =
        merge16(en[{wr_addr[4:2], 4'h0} +: 16], wdata_h, wstrb_h);
    if (wr_do && wa == `VIC_OFF_TRAP)
      next_trap = merge16(trap, wdata_h, wstrb_h);
    next_flags = (next_flags | {10'h000, line_sync[`VIC_NIRQ-1:0]}) & `VIC_FLAG_MASK;
    next_en    = next_en & `VIC_FLAG_MASK;
    next_trap  = (next_trap | {11'h000, line_sync[`VIC_NSYNC-1:`VIC_NIRQ], 1'b0})
               & `VIC_TRAP_MASK;
  end

  // Scan step: strict greater-than keeps the lower vector on a tie
  always @*
  begin
    cand_p  = mem_a[{eval_num[1:0], 2'h0} +: 3];
    next_bv = best_v;
    next_bn = best_n;
    next_bp = best_p;
    if (eval_ok && flags[eval_num] && en[eval_num]
        && {1'b0, cand_p} > cpu_level_out
        && (!best_v || cand_p > best_p))
    begin
      next_bv = 1'b1;
      next_bn = eval_num;
      next_bp = cand_p;
    end
  end

  // Trap pick: lowest pending trap above the current level
  always @*
  begin
    trap_hit = 1'b0;
    trap_n   = 7'h00;
    for (n = 4; n >= 1; n = n - 1)
      if (trap[n] && (`VIC_TRAP_TOP - n[3:0]) > cpu_level_out)
      begin
        trap_hit = 1'b1;
        trap_n   = n[6:0];
      end
  end

  // Register state; cleared on reset with no controller involvement
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      flags <= 128'h0;
      en    <= 128'h0;
      trap  <= `VIC_ZERO16;
      ctrl2 <= `VIC_ZERO16;
    end
    else
    begin
      flags <= next_flags;
      en    <= next_en;
      trap  <= next_trap;
      if (wr_do && wa == `VIC_OFF_CTRL2)
        ctrl2 <= merge16(ctrl2, wdata_h, wstrb_h) & `VIC_CTRL2_MASK;
    end
  end

  // Core level and status latch; the high level bit is never software-written
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      cpu_level_out <= 4'h0;
      stat_num      <= 7'h00;
      stat_lvl      <= 4'h0;
    end
    else if (ack_take)
    begin
      cpu_level_out <= new_level_out;
      stat_num      <= vec_num_out;
      stat_lvl      <= new_level_out;
    end
    else if (core_ret_in)
      cpu_level_out <= core_ret_level_in;
    else if (level_wr)
      cpu_level_out <= {cpu_level_out[3], wdata_h[2:0]};
  end

  // Full scan every time keeps the entry latency independent of data
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      idx          <= 7'h00;
      eval_num     <= 7'h00;
      eval_ok      <= 1'b0;
      best_v       <= 1'b0;
      best_n       <= 7'h00;
      best_p       <= 3'h0;
      irq_req_out  <= 1'b0;
      vec_addr_out <= 24'h000000;
      vec_num_out  <= 7'h00;
      new_level_out <= 4'h0;
    end
    else if (restart)
    begin
      idx         <= 7'h00;
      eval_ok     <= 1'b0;
      best_v      <= 1'b0;
      irq_req_out <= 1'b0;
    end
    else
    begin
      idx      <= (idx == `VIC_LAST_IRQ) ? 7'h00 : idx + 7'h01;
      eval_num <= idx;
      eval_ok  <= 1'b1;
      best_n   <= next_bn;
      best_p   <= next_bp;
      best_v   <= finalize ? 1'b0 : next_bv;
      if (finalize)
      begin
        irq_req_out <= trap_hit || next_bv;
        if (trap_hit)
        begin
          vec_num_out   <= trap_n;
          new_level_out <= `VIC_TRAP_TOP - trap_n[3:0];
          vec_addr_out  <= vec_addr(trap_n, ctrl2[`VIC_ALT_BIT]);
        end
        else
        begin
          vec_num_out   <= next_bn + `VIC_IRQ_BASE;
          new_level_out <= {1'b0, next_bp};
          vec_addr_out  <= vec_addr(next_bn + `VIC_IRQ_BASE, ctrl2[`VIC_ALT_BIT]);
        end
      end
    end
  end

  // Write address and data taken in either order, response after both
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      wr_addr           <= 12'h000;
      wdata_h           <= `VIC_ZERO16;
      wstrb_h           <= 2'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `VIC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held           <= 1'b1;
        wr_addr           <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      else if (!aw_held && !s_axi_bvalid_out)
        s_axi_awready_out <= 1'b1;
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held           <= 1'b1;
        wdata_h          <= s_axi_wdata_in[15:0];
        wstrb_h          <= s_axi_wstrb_in[1:0];
        s_axi_wready_out <= 1'b0;
      end
      else if (!w_held && !s_axi_bvalid_out)
        s_axi_wready_out <= 1'b1;
      if (wr_do)
      begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= mapped(wr_addr) ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  // Read data selection; unused upper bits read zero
  always @*
  begin
    rd_mux = `VIC_ZERO16;
    if (in_win(rd_addr, `VIC_OFF_FLAG, `VIC_SPAN_FLAG))
      rd_mux = flags[{rd_addr[4:2], 4'h0} +: 16];
    else if (in_win(rd_addr, `VIC_OFF_EN, `VIC_SPAN_FLAG))
      rd_mux = en[{rd_addr[4:2], 4'h0} +: 16];
    else if (in_win(rd_addr, `VIC_OFF_PRI, `VIC_SPAN_PRI))
      rd_mux = mem_b;
    else if (ra == `VIC_OFF_CTRL2)
      rd_mux = ctrl2;
    else if (ra == `VIC_OFF_LEVEL)
      rd_mux = {12'h000, cpu_level_out};
    else if (ra == `VIC_OFF_TRAP)
      rd_mux = trap;
    else if (ra == `VIC_OFF_STAT)
      rd_mux = {4'h0, stat_lvl, 1'b0, stat_num};
  end

  // Read path waits one cycle for the registered memory port
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      rd_addr           <= 12'h000;
      rd_stage          <= RD_IDLE;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `VIC_RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      rd_addr           <= s_axi_araddr_in;
      s_axi_arready_out <= 1'b0;
      rd_stage          <= RD_WAIT;
    end
    else if (rd_stage == RD_WAIT)
      rd_stage <= RD_LOAD;
    else if (rd_stage == RD_LOAD)
    begin
      rd_stage         <= RD_IDLE;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= {16'h0000, rd_mux};
      s_axi_rresp_out  <= mapped(rd_addr) ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
    end
    else if (s_axi_rvalid_out && s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
    else if (!s_axi_rvalid_out)
      s_axi_arready_out <= 1'b1;
  end

endmodule // vic_top

// ---- bench/vic_properties.sv ----
// Port-level checker for the vectored interrupt controller
`timescale 1ns/100ps
module vic_checker
(
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  // Core link
  input wire logic        core_ack_in,
  input wire logic        core_ret_in,
  input wire logic [3:0]  core_ret_level_in,
  input wire logic        irq_req_out,
  input wire logic [23:0] vec_addr_out,
  input wire logic [6:0]  vec_num_out,
  input wire logic [3:0]  new_level_out,
  input wire logic [3:0]  cpu_level_out,
  // Register bus
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out
);
  // One clock domain, so one default clocking and reset
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_ack_taken: assert property (
    core_ack_in && irq_req_out |=> !irq_req_out && cpu_level_out == $past(new_level_out))
    else $error("ack not honoured");
  // Scan restarts on ack, so no new request can follow within a few cycles
  a_ack_quiet: assert property (
    core_ack_in && irq_req_out |=> !irq_req_out [*8])
    else $error("request too soon after ack");
  a_ret_level: assert property (
    core_ret_in && !(core_ack_in && irq_req_out) |=> cpu_level_out == $past(core_ret_level_in))
    else $error("return level not restored");
  a_addr_map: assert property (
    irq_req_out |-> vec_addr_out[23:9] == 15'h0000
                    && vec_addr_out[7:0] == 8'h04 + {vec_num_out, 1'b0})
    else $error("vector address wrong");
  a_trap_level: assert property (
    irq_req_out && vec_num_out < 7'h08 |-> new_level_out == 4'hF - {1'b0, vec_num_out[2:0]})
    else $error("trap level wrong");
  a_irq_above: assert property (
    irq_req_out && vec_num_out >= 7'h08
    |-> new_level_out != 4'h0 && new_level_out <= 4'h7 && new_level_out > cpu_level_out)
    else $error("user request not above level");
  a_vec_range: assert property (
    irq_req_out |-> vec_num_out <= 7'h7D && !(vec_num_out inside {7'h00, 7'h05, 7'h06, 7'h07}))
    else $error("vector number out of range");
  a_req_hold: assert property (
    irq_req_out && !core_ack_in && !core_ret_in && !s_axi_awvalid_in && !s_axi_wvalid_in
    |=> (irq_req_out && $stable(vec_addr_out) && $stable(vec_num_out))
        || $rose(s_axi_bvalid_out))
    else $error("request not held");
  // Read data is valid three cycles after the read address handshake
  a_read_lat: assert property (
    s_axi_arvalid_in && s_axi_arready_out |-> ##3 s_axi_rvalid_out)
    else $error("read answer late");
  a_rdata_upper: assert property (
    s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000)
    else $error("upper read lanes not zero");
endmodule // vic_checker

bind vic_top vic_checker chk_u
(
  .clk_in,
  .sys_rst_in,
  .core_ack_in,
  .core_ret_in,
  .core_ret_level_in,
  .irq_req_out,
  .vec_addr_out,
  .vec_num_out,
  .new_level_out,
  .cpu_level_out,
  .s_axi_awvalid_in,
  .s_axi_wvalid_in,
  .s_axi_bvalid_out,
  .s_axi_arvalid_in,
  .s_axi_arready_out,
  .s_axi_rvalid_out,
  .s_axi_rdata_out
);

// ---- bench/vic_core_model.sv ----
// Processor core model: takes presented requests, returns on command
`timescale 1ns/100ps
module vic_core_model
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Controller side
  input  wire logic        irq_req_in,
  input  wire logic [23:0] vec_addr_in,
  input  wire logic [6:0]  vec_num_in,
  input  wire logic [3:0]  new_level_in,
  output logic             ack_out,
  output logic             ret_out,
  output logic [3:0]       ret_level_out,
  // Bench control and record
  input  wire logic        ret_go_in,
  output logic [34:0]      taken_out,
  output logic [7:0]       taken_cnt_out
);
  // Always restore level zero, so any pending source may fire again
  assign ret_level_out = 4'h0;

  // Ack is a single pulse so one request is never taken twice
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      ack_out       <= 1'b0;
      ret_out       <= 1'b0;
      taken_out     <= 35'h0;
      taken_cnt_out <= 8'h00;
    end
    else
    begin
      ack_out <= irq_req_in && !ack_out;
      ret_out <= ret_go_in;
      if (ack_out && irq_req_in)
      begin
        taken_out     <= {new_level_in, vec_num_in, vec_addr_in};
        taken_cnt_out <= taken_cnt_out + 8'h01;
      end
    end
  end
endmodule // vic_core_model

// ---- bench/testbench.sv ----
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
module testbench;
  logic         clk_in = 1'b0;
  logic         sys_rst_in = 1'b1;
  logic [117:0] irq_line = '0;
  logic [3:0]   trap_ev = 4'h0;
  logic [11:0]  awaddr = 12'h000;
  logic [11:0]  araddr = 12'h000;
  logic [31:0]  wdata = 32'h0;
  logic         awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic         ret_go = 1'b0;
  logic         ack, ret, req, awr, wr, bv, arr, rv;
  logic [3:0]   ret_lvl, new_lvl, cpu_lvl;
  logic [23:0]  vaddr;
  logic [6:0]   vnum;
  logic [34:0]  taken;
  logic [7:0]   tcnt;
  logic [31:0]  rdata;
  logic [1:0]   bresp, rresp;
  int           fail_count = 0, checked = 0, cycles = 0, lat_irq, lat_trap, spare;

  vic_top dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .irq_line_in(irq_line),
    .trap_event_in(trap_ev), .core_ack_in(ack), .core_ret_in(ret),
    .core_ret_level_in(ret_lvl), .irq_req_out(req), .vec_addr_out(vaddr),
    .vec_num_out(vnum), .new_level_out(new_lvl), .cpu_level_out(cpu_lvl),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rready));
  vic_core_model core_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .irq_req_in(req),
    .vec_addr_in(vaddr), .vec_num_in(vnum), .new_level_in(new_lvl), .ack_out(ack),
    .ret_out(ret), .ret_level_out(ret_lvl), .ret_go_in(ret_go), .taken_out(taken),
    .taken_cnt_out(tcnt));

  // Clock and hang guard; the run needs well under a tenth of the ceiling
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Bus write: address and data offered together, bready held until bvalid
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
    end while (!(bv && bready) && n < 100);
    bready <= 1'b0;
    check("bvalid", 32'h1, {31'h0, bv});
    check("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge clk_in);
  endtask

  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (arr)
        arv <= 1'b0;
    end while (!(rv && rready) && n < 100);
    rready <= 1'b0;
    check("rvalid", 32'h1, {31'h0, rv});
    check("rresp", {30'h0, er}, {30'h0, rresp});
    check("rdata", exp, rdata);
    @(posedge clk_in);
  endtask

  // Wait for the core to take a request, then judge what it was handed
  task automatic take(input logic [6:0] num, input logic [23:0] addr, input logic [3:0] lvl);
    logic [7:0] c0;
    int n;
    c0 = tcnt;
    n = 0;
    while (tcnt === c0 && n < 600)
    begin
      @(posedge clk_in);
      n++;
    end
    check("taken", 32'h1, {31'h0, tcnt !== c0});
    check("vec_addr", {8'h00, addr}, {8'h00, taken[23:0]});
    check("vec_num", {25'h0, num}, {25'h0, taken[30:24]});
    check("new_level", {28'h0, lvl}, {28'h0, taken[34:31]});
    check("cpu_level", {28'h0, lvl}, {28'h0, cpu_lvl});
  endtask

  // Return to level zero; count edges from the return to the next request
  task automatic ret_lat(input int lim, output int lat);
    ret_go <= 1'b1;
    @(posedge clk_in);
    ret_go <= 1'b0;
    lat = -1;
    do
    begin
      @(posedge clk_in);
      #1;
      lat++;
    end while (req !== 1'b1 && lat < lim);
    @(posedge clk_in);
  endtask

  task automatic pulse(input int b);
    irq_line[b] <= 1'b1;
    repeat (4) @(posedge clk_in);
    irq_line <= '0;
  endtask

  task automatic no_req(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge clk_in);
      seen = seen | req;
    end
    check("irq_req", 32'h0, {31'h0, seen});
  endtask

  task automatic t_reset();
    rd_reg(12'h180, 32'h0, 2'h0);
    rd_reg(12'h184, 32'h0, 2'h0);
    rd_reg(12'h18C, 32'h0, 2'h0);
    rd_reg(12'h1F0, 32'h0, 2'h2);
    wr_reg(12'h1F0, 32'hFFFF, 2'h2);
    no_req(20);
  endtask

  task automatic t_single();
    wr_reg(12'h08C, 32'h0040, 2'h0);
    wr_reg(12'h040, 32'h2000, 2'h0);
    pulse(13);
    take(7'h15, 24'h00002E, 4'h4);
    rd_reg(12'h18C, 32'h0415, 2'h0);
    rd_reg(12'h000, 32'h2000, 2'h0);
    ret_lat(400, lat_irq);
    take(7'h15, 24'h00002E, 4'h4);
    check("latency", 32'd119, lat_irq);
    wr_reg(12'h000, 32'h0, 2'h0);
    ret_lat(2, spare);
  endtask

  task automatic t_trap();
    wr_reg(12'h184, 32'hF, 2'h0);
    rd_reg(12'h184, 32'h7, 2'h0);
    trap_ev[2] <= 1'b1;
    repeat (4) @(posedge clk_in);
    trap_ev <= 4'h0;
    take(7'h03, 24'h00000A, 4'hC);
    rd_reg(12'h188, 32'h0008, 2'h0);
    wr_reg(12'h180, 32'h8000, 2'h0);
    rd_reg(12'h180, 32'h8000, 2'h0);
    ret_lat(400, lat_trap);
    take(7'h03, 24'h00010A, 4'hC);
    check("latency", 32'd119, lat_trap);
    wr_reg(12'h188, 32'h0, 2'h0);
    wr_reg(12'h180, 32'h0, 2'h0);
    ret_lat(2, spare);
  endtask

  // Two sources at one level plus a lower-level, lower-numbered one
  task automatic t_order();
    wr_reg(12'h0C0, 32'h3000, 2'h0);
    wr_reg(12'h0CC, 32'h0030, 2'h0);
    wr_reg(12'h084, 32'h0020, 2'h0);
    wr_reg(12'h050, 32'h2008, 2'h0);
    wr_reg(12'h040, 32'h0020, 2'h0);
    irq_line[5] <= 1'b1;
    irq_line[67] <= 1'b1;
    pulse(77);
    take(7'h4B, 24'h00009A, 4'h3);
    wr_reg(12'h010, 32'h2000, 2'h0);
    ret_lat(400, spare);
    take(7'h55, 24'h0000AE, 4'h3);
    wr_reg(12'h010, 32'h0, 2'h0);
    ret_lat(400, spare);
    take(7'h0D, 24'h00001E, 4'h2);
    wr_reg(12'h000, 32'h0, 2'h0);
    ret_lat(2, spare);
  endtask

  task automatic t_mask();
    wr_reg(12'h080, 32'hFFFF, 2'h0);
    rd_reg(12'h080, 32'h7777, 2'h0);
    wr_reg(12'h080, 32'h0, 2'h0);
    wr_reg(12'h040, 32'h0002, 2'h0);
    pulse(1);
    no_req(300);
    wr_reg(12'h080, 32'h0050, 2'h0);
    wr_reg(12'h040, 32'h0, 2'h0);
    no_req(300);
    wr_reg(12'h184, 32'h5, 2'h0);
    wr_reg(12'h040, 32'h0002, 2'h0);
    no_req(300);
    wr_reg(12'h184, 32'h4, 2'h0);
    take(7'h09, 24'h000016, 4'h5);
  endtask

  initial
  begin
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_single();
    t_trap();
    t_order();
    t_mask();
    summarize();
  end
endmodule // testbench
